// ===== hdl/ext_irq_consts.svh
// Offsets, field positions, reset values and widths of the edge-select block.
`ifndef EXT_IRQ_CONSTS_SVH
`define EXT_IRQ_CONSTS_SVH

`define T3_EDGE_ADDR        32'h0FFFF689
`define T1_EDGE_ADDR        32'h3FFFDA20
`define T3_BITOP_ADDR       32'h3FFFDA28
`define PIN_LEVEL_ADDR      32'h3FFFDA2C

`define T3_EDGE_RESET       8'h00
`define T1_EDGE_RESET       4'h0

`define T3_COUNT_FIELD_LSB  6
`define T3_CLEAR_FIELD_LSB  4
`define T3_IRQ1_FIELD_LSB   2
`define T3_IRQ0_FIELD_LSB   0
`define T1_IRQ_B_FIELD_LSB  2
`define T1_IRQ_A_FIELD_LSB  0

`define BITOP_VALUE_BIT     3
`define BITOP_INDEX_MSB     2

`define EDGE_FALLING        2'h0
`define EDGE_RISING         2'h1
`define EDGE_RESERVED       2'h2
`define EDGE_BOTH           2'h3

`define NUM_EDGE_CH         6

`endif

// ===== hdl/ext_irq_pkg.sv
// Types shared by the edge-select block and its users.
package ext_irq_pkg;

    typedef logic [1:0] edge_code_t;

    typedef struct packed {
        edge_code_t count;
        edge_code_t clear;
        edge_code_t irq1;
        edge_code_t irq0;
    } t3_edge_sel_t;

    typedef struct packed {
        edge_code_t irq_b;
        edge_code_t irq_a;
    } t1_edge_sel_t;

    // One bit per input, in channel order: t1 a, t1 b, t3 irq0, t3 irq1, t3 clear, t3 count.
    typedef struct packed {
        logic t3_count;
        logic t3_clear;
        logic t3_irq1;
        logic t3_irq0;
        logic t1_irq_b;
        logic t1_irq_a;
    } edge_vec_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage

// ===== hdl/ext_irq_edge_select.sv
// Edge selection and detection for the timer-1 and timer-3 external inputs.
//
// How it works
// - Timer-1 irq A edge code in bits 1..0, B above; 00 fall, 01 rise, 11 both.
// - Each of the four timer-3 inputs has its own edge code, 10 reserved.
// - Timer-3 fields: count 7..6, clear 5..4, irq 31 in 3..2, irq 30 in 1..0.
// - Timer-3 edge register is reachable as a whole byte or by single bits.
// - Changing port mode after edge selection may cause a spurious request.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`include "ext_irq_consts.svh"

module ext_irq_edge_select (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire ext_irq_pkg::reg_req_t  bus_req,
    output logic [31:0]                 rdata,
    input  wire ext_irq_pkg::edge_vec_t port_mode_control,
    input  wire logic                   t3_count_enable,
    input  wire logic                   t3_clock_enable,
    input  wire logic                   t1_ext_irq_a,
    input  wire logic                   t1_ext_irq_b,
    input  wire logic                   t3_ext_irq_0,
    input  wire logic                   t3_ext_irq_1,
    input  wire logic                   t3_clear_input,
    input  wire logic                   t3_count_input,
    output ext_irq_pkg::edge_vec_t      edge_req
);
    import ext_irq_pkg::*;

    logic         rst_meta_ff;
    logic         rst_sync_ff;
    t3_edge_sel_t t3_sel_ff;
    t3_edge_sel_t nxt_t3_sel;
    t1_edge_sel_t t1_sel_ff;
    t1_edge_sel_t nxt_t1_sel;
    logic [31:0]  nxt_rdata;
    edge_vec_t    pin_vec;
    edge_vec_t    gate_vec;
    edge_vec_t    cur_ff;
    edge_vec_t    prev_ff;
    edge_vec_t    hit_vec;
    edge_vec_t    edge_req_ff;
    edge_code_t   code_vec [`NUM_EDGE_CH];

    // Reset is released through two flip-flops; the whole block uses the copy.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Register decode.
    wire       hit_t3    = bus_req.addr == `T3_EDGE_ADDR;
    wire       hit_t1    = bus_req.addr == `T1_EDGE_ADDR;
    wire       hit_bitop = bus_req.addr == `T3_BITOP_ADDR;
    wire       hit_pins  = bus_req.addr == `PIN_LEVEL_ADDR;
    wire       wr_t3     = bus_req.wr && hit_t3;
    wire       wr_t1     = bus_req.wr && hit_t1;
    wire       wr_bitop  = bus_req.wr && hit_bitop;
    wire [2:0] bit_index = bus_req.wdata[`BITOP_INDEX_MSB:0];
    wire       bit_value = bus_req.wdata[`BITOP_VALUE_BIT];

    // A single-bit write changes one bit and leaves the other seven alone.
    logic [7:0] t3_bit_written;
    always_comb begin
        t3_bit_written = t3_sel_ff;
        t3_bit_written[bit_index] = bit_value;
    end

    assign nxt_t3_sel = wr_t3    ? t3_edge_sel_t'(bus_req.wdata[7:0]) :
                        wr_bitop ? t3_edge_sel_t'(t3_bit_written) :
                                   t3_sel_ff;
    assign nxt_t1_sel = wr_t1 ? t1_edge_sel_t'(bus_req.wdata[3:0]) : t1_sel_ff;

    // Unmapped addresses read as zero; reads have no side effect.
    assign nxt_rdata = !bus_req.rd ? 32'h00000000 :
                       hit_t3      ? {24'h000000, t3_sel_ff} :
                       hit_bitop   ? {24'h000000, t3_sel_ff} :
                       hit_t1      ? {28'h0000000, t1_sel_ff} :
                       hit_pins    ? {26'h0000000, cur_ff} :
                                     32'h00000000;

    always_ff @(posedge clock or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            t3_sel_ff <= `T3_EDGE_RESET;
            t1_sel_ff <= `T1_EDGE_RESET;
            rdata     <= 32'h00000000;
        end else begin
            t3_sel_ff <= nxt_t3_sel;
            t1_sel_ff <= nxt_t1_sel;
            rdata     <= nxt_rdata;
        end
    end

    // Per-channel edge codes in channel order.
    assign code_vec[0] = t1_sel_ff.irq_a;
    assign code_vec[1] = t1_sel_ff.irq_b;
    assign code_vec[2] = t3_sel_ff.irq0;
    assign code_vec[3] = t3_sel_ff.irq1;
    assign code_vec[4] = t3_sel_ff.clear;
    assign code_vec[5] = t3_sel_ff.count;

    assign pin_vec = '{t3_count: t3_count_input, t3_clear: t3_clear_input,
                       t3_irq1: t3_ext_irq_1, t3_irq0: t3_ext_irq_0,
                       t1_irq_b: t1_ext_irq_b, t1_irq_a: t1_ext_irq_a};

    // The shared timer-3 pins reach the interrupt path only with both timer enables set.
    wire t3_irq_open = t3_count_enable && t3_clock_enable;
    assign gate_vec = '{t3_count: 1'b1, t3_clear: 1'b1,
                        t3_irq1: t3_irq_open, t3_irq0: t3_irq_open,
                        t1_irq_b: 1'b1, t1_irq_a: 1'b1};

    genvar ch;
    generate
        for (ch = 0; ch < `NUM_EDGE_CH; ch = ch + 1) begin : g_edge
            // Outside pin mode the detector sees a low level, so switching the pin in
            // while it is high looks like a rising edge; the caution on ordering stands.
            wire level = port_mode_control[ch] && pin_vec[ch];
            wire rise  = cur_ff[ch] && !prev_ff[ch];
            wire fall  = !cur_ff[ch] && prev_ff[ch];
            // The reserved code detects nothing rather than guessing an edge.
            assign hit_vec[ch] = gate_vec[ch] && (
                                 (code_vec[ch] == `EDGE_FALLING && fall) ||
                                 (code_vec[ch] == `EDGE_RISING  && rise) ||
                                 (code_vec[ch] == `EDGE_BOTH && (rise || fall)));

            always_ff @(posedge clock or negedge rst_sync_ff) begin
                if (!rst_sync_ff) begin
                    cur_ff[ch]      <= 1'b0;
                    prev_ff[ch]     <= 1'b0;
                    edge_req_ff[ch] <= 1'b0;
                end else begin
                    cur_ff[ch]      <= level;
                    prev_ff[ch]     <= cur_ff[ch];
                    edge_req_ff[ch] <= hit_vec[ch];
                end
            end
        end
    endgenerate

    assign edge_req = edge_req_ff;

endmodule

// ===== verif/ext_irq_edge_select_assertions.sv
// Port assertions for the edge-select block.
`timescale 1ns/1ps
`include "ext_irq_consts.svh"
module ext_irq_edge_select_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire ext_irq_pkg::reg_req_t bus_req,
    input wire logic [31:0] rdata,
    input wire ext_irq_pkg::edge_vec_t port_mode_control,
    input wire logic t3_count_enable,
    input wire logic t3_clock_enable,
    input wire logic t1_ext_irq_a,
    input wire logic t1_ext_irq_b,
    input wire logic t3_ext_irq_0,
    input wire logic t3_ext_irq_1,
    input wire logic t3_clear_input,
    input wire logic t3_count_input,
    input wire ext_irq_pkg::edge_vec_t edge_req
);
    import ext_irq_pkg::*;
    // A mode change alone moves these levels, which is why it can raise a request.
    wire logic [5:0] lvl = port_mode_control & {t3_count_input, t3_clear_input,
        t3_ext_irq_1, t3_ext_irq_0, t1_ext_irq_b, t1_ext_irq_a};
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_rd_idle: assert property (!$past(bus_req.rd) |-> rdata == 32'h0)
        else $error("read data without a read");
    a_t1_cause: assert property (
        (edge_req & 6'h03 & ~($past(lvl, 2) ^ $past(lvl, 3))) == 6'h0)
        else $error("timer-1 request without a level change");
    a_t3_cause: assert property (
        (edge_req & 6'h3C & ~($past(lvl, 2) ^ $past(lvl, 3))) == 6'h0)
        else $error("timer-3 request without a level change");
    a_t3_gated: assert property (!t3_count_enable [*4] |=> edge_req[3:2] == 2'h0)
        else $error("timer-3 interrupt while timer disabled");
    a_t3_clk_gated: assert property (!t3_clock_enable [*4] |=> edge_req[3:2] == 2'h0)
        else $error("timer-3 interrupt while timer clock disabled");
    a_t3_readback: assert property (
        bus_req.rd && bus_req.addr == `T3_EDGE_ADDR && $past(bus_req.wr)
        && $past(bus_req.addr) == `T3_EDGE_ADDR |=> rdata == ($past(bus_req.wdata, 2) & 32'hFF))
        else $error("edge register read back wrong");
    a_unmapped_zero: assert property (
        bus_req.rd && bus_req.addr == 32'h3FFFDA30 |=> rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule

// ===== verif/ext_pin_model.sv
// External pins that follow the requested levels one cycle later.
`timescale 1ns/1ps
module ext_pin_model (
    input wire logic clock,
    input wire ext_irq_pkg::edge_vec_t want,
    output ext_irq_pkg::edge_vec_t pin
);
    import ext_irq_pkg::*;
    initial pin = '0;
    always @(posedge clock) begin
        pin <= want;
    end
endmodule

// ===== verif/ext_irq_edge_select_tb.sv
// Self-checking bench for the edge-select block.
`timescale 1ns/1ps
`include "ext_irq_consts.svh"
module ext_irq_edge_select_tb;
    import ext_irq_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    reg_req_t bus_req = '0;
    logic [31:0] rdata;
    edge_vec_t pmc = '0;
    edge_vec_t want = '0;
    edge_vec_t pin;
    edge_vec_t edge_req;
    logic cnt_en = 1'b1;
    logic clk_en = 1'b1;
    int mismatches = 0;
    int checks_done = 0;
    edge_code_t code [4] = '{`EDGE_FALLING, `EDGE_RISING, `EDGE_BOTH, `EDGE_RESERVED};
    always #5 clock = ~clock;
    ext_pin_model u_pins (.clock(clock), .want(want), .pin(pin));
    ext_irq_edge_select u_dut (.clock(clock), .rst_n(rst_n), .bus_req(bus_req),
        .rdata(rdata), .port_mode_control(pmc), .t3_count_enable(cnt_en),
        .t3_clock_enable(clk_en), .t1_ext_irq_a(pin.t1_irq_a), .t1_ext_irq_b(pin.t1_irq_b),
        .t3_ext_irq_0(pin.t3_irq0), .t3_ext_irq_1(pin.t3_irq1),
        .t3_clear_input(pin.t3_clear), .t3_count_input(pin.t3_count), .edge_req(edge_req));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req <= '{a, d, 1'b1, 1'b0};
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clock);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clock);
        bus_req <= '0;
        #1 chk(rdata, exp, "rdata");
    endtask
    // Counting pulses as well as OR-ing them catches a request held for two cycles.
    task automatic step(input edge_vec_t p, input edge_vec_t l, input edge_vec_t exp);
        edge_vec_t seen;
        int n;
        seen = '0;
        n = 0;
        @(posedge clock);
        bus_req <= '0;
        pmc <= p;
        want <= l;
        repeat (8) begin
            @(negedge clock);
            seen = seen | edge_req;
            n = n + $countones(edge_req);
        end
        chk({26'h0, seen}, {26'h0, exp}, "edge_req");
        chk(n, $countones(exp), "pulses");
    endtask
    function automatic edge_vec_t hit(input logic [11:0] c, input logic rise);
        edge_vec_t v;
        for (int k = 0; k < 6; k++) begin
            v[k] = c[2*k +: 2] == `EDGE_BOTH
                || c[2*k +: 2] == (rise ? `EDGE_RISING : `EDGE_FALLING);
        end
        return v;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #20000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        logic [11:0] c;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`T3_EDGE_ADDR, 32'h0);
        rd(`T1_EDGE_ADDR, 32'h0);
        wr(32'h3FFFDA30, 32'hFF);
        rd(32'h3FFFDA30, 32'h0);
        wr(`T3_EDGE_ADDR, 32'h41);
        rd(`T3_EDGE_ADDR, 32'h41);
        wr(`T3_BITOP_ADDR, 32'hF);
        wr(`T3_BITOP_ADDR, 32'h0);
        rd(`T3_EDGE_ADDR, 32'hC0);
        rd(`T3_BITOP_ADDR, 32'hC0);
        $display("register test done");
        wr(`T3_EDGE_ADDR, 32'h55);
        wr(`T1_EDGE_ADDR, 32'h5);
        step('0, '1, '0);
        rd(`PIN_LEVEL_ADDR, 32'h0);
        step('1, '1, '1);
        rd(`PIN_LEVEL_ADDR, 32'h3F);
        $display("mode change test done");
        for (int i = 0; i < 4; i++) begin
            for (int k = 0; k < 6; k++)
                c[2*k +: 2] = code[(i + k) % 4];
            wr(`T3_EDGE_ADDR, {24'h0, c[11:4]});
            wr(`T1_EDGE_ADDR, {28'h0, c[3:0]});
            step('1, '0, hit(c, 1'b0));
            step('1, '1, hit(c, 1'b1));
        end
        $display("edge code test done");
        @(posedge clock);
        cnt_en <= 1'b0;
        wr(`T3_EDGE_ADDR, 32'hFF);
        wr(`T1_EDGE_ADDR, 32'hF);
        step('1, '0, 6'h33);
        // Each timer enable must close the shared pins on its own.
        @(posedge clock);
        cnt_en <= 1'b1;
        clk_en <= 1'b0;
        step('1, '1, 6'h33);
        @(posedge clock);
        clk_en <= 1'b1;
        step('1, '0, 6'h3F);
        $display("timer gate test done");
        tally_and_finish();
    end
endmodule
bind ext_irq_edge_select ext_irq_edge_select_chk u_chk (.clock, .rst_n, .bus_req, .rdata,
    .port_mode_control, .t3_count_enable, .t3_clock_enable, .t1_ext_irq_a, .t1_ext_irq_b,
    .t3_ext_irq_0, .t3_ext_irq_1, .t3_clear_input, .t3_count_input, .edge_req);
